// File: core/switch_cfg_pkg.sv
package switch_cfg_pkg;

	// ----------------------------------------
	// per-word access attributes
	// ----------------------------------------
	typedef struct packed {
		logic        impl;
		logic [31:0] rst;
		logic [31:0] rw;
		logic [31:0] w1c;
		logic [31:0] stk;
		logic [31:0] pre;
	} attr_t;

	// ----------------------------------------
	// byte offsets of the type 1 header and the capability words after it
	// ----------------------------------------
	localparam logic [7:0] OFS_IDENT_WORD     = 8'h00;
	localparam logic [7:0] OFS_COMMAND_STATUS = 8'h04;
	localparam logic [7:0] OFS_CLASS_REVISION = 8'h08;
	localparam logic [7:0] OFS_HEADER_TYPE    = 8'h0c;
	localparam logic [7:0] OFS_BUS_NUMBERS    = 8'h18;
	localparam logic [7:0] OFS_IO_WINDOW      = 8'h1c;
	localparam logic [7:0] OFS_MEMORY_WINDOW  = 8'h20;
	localparam logic [7:0] OFS_PREFETCH_WIN   = 8'h24;
	localparam logic [7:0] OFS_PREF_BASE_HI   = 8'h28;
	localparam logic [7:0] OFS_PREF_LIMIT_HI  = 8'h2c;
	localparam logic [7:0] OFS_IO_WINDOW_HI   = 8'h30;
	localparam logic [7:0] OFS_FIRST_CAP_PTR  = 8'h34;
	localparam logic [7:0] OFS_INTR_BRIDGE    = 8'h3c;
	localparam logic [7:0] OFS_POWER_CAP      = 8'h40;
	localparam logic [7:0] OFS_POWER_CTRL     = 8'h44;
	localparam logic [7:0] OFS_MSI_CAP        = 8'h4c;
	localparam logic [7:0] OFS_MSI_ADDR_LO    = 8'h50;
	localparam logic [7:0] OFS_MSI_ADDR_HI    = 8'h54;
	localparam logic [7:0] OFS_MSI_PAYLOAD    = 8'h58;
	localparam logic [7:0] OFS_PRODUCT_CAP    = 8'h5c;
	localparam logic [7:0] OFS_PRODUCT_WORD   = 8'h60;
	localparam logic [7:0] OFS_VENDOR_CAP     = 8'h64;
	localparam logic [7:0] OFS_LINK_WORD0     = 8'h68;
	localparam logic [7:0] OFS_LINK_WORD1     = 8'h6c;
	localparam logic [7:0] OFS_ACK_REPLAY     = 8'h70;
	localparam logic [7:0] OFS_SWITCH_MODES   = 8'h74;
	localparam logic [7:0] OFS_PHY1_WORD2     = 8'h78;
	localparam logic [7:0] OFS_PHY_PARAM2     = 8'h7c;
	localparam logic [7:0] OFS_LINK_WORD3     = 8'h80;
	localparam logic [7:0] OFS_LINK_WORD4     = 8'h84;
	localparam logic [7:0] OFS_LINK_WORD5     = 8'h88;
	localparam logic [7:0] OFS_TRANS_LINK     = 8'h8c;
	localparam logic [7:0] OFS_PHY_PARAM3     = 8'h90;
	localparam logic [7:0] OFS_PHY_TX_MARGIN  = 8'h94;
	localparam logic [7:0] OFS_BUFFER_OP_MODE = 8'h98;
	localparam logic [7:0] OFS_SUBSYS_CAP     = 8'hb0;
	localparam logic [7:0] OFS_SUBSYS_IDENT   = 8'hb4;
	localparam logic [7:0] OFS_PIN_IO         = 8'hb8;
	localparam logic [7:0] OFS_SERIAL_ROM     = 8'hbc;
	localparam logic [7:0] OFS_PCIE_CAP       = 8'hc0;
	localparam logic [7:0] OFS_DEVICE_CAPS    = 8'hc4;
	localparam logic [7:0] OFS_DEVICE_CTRL    = 8'hc8;
	localparam logic [7:0] OFS_LINK_CAPS      = 8'hcc;
	localparam logic [7:0] OFS_LINK_CTRL      = 8'hd0;
	localparam logic [7:0] OFS_SLOT_CAPS      = 8'hd4;
	localparam logic [7:0] OFS_SLOT_CTRL      = 8'hd8;
	localparam logic [7:0] OFS_DEVICE_CAPS2   = 8'he4;
	localparam logic [7:0] OFS_DEVICE_CTRL2   = 8'he8;
	localparam logic [7:0] OFS_LINK_CAPS2     = 8'hec;
	localparam logic [7:0] OFS_LINK_CTRL2     = 8'hf0;
	localparam logic [7:0] OFS_SLOT_CAPS2     = 8'hf4;
	localparam logic [7:0] OFS_SLOT_CTRL2     = 8'hf8;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [31:0] RST_COMMAND_STATUS = 32'h0010_0000;
	localparam logic [31:0] RST_CLASS_REVISION = 32'h0604_0000;
	localparam logic [31:0] RST_HEADER_TYPE    = 32'h0001_0000;
	localparam logic [31:0] RST_IO_WINDOW      = 32'h0000_0101;
	localparam logic [31:0] RST_PREFETCH_WIN   = 32'h0001_0001;
	localparam logic [31:0] RST_FIRST_CAP_PTR  = 32'h0000_0040;
	localparam logic [31:0] RST_INTR_BRIDGE    = 32'h0000_0100;
	localparam logic [31:0] RST_POWER_CAP      = 32'h0003_4c01;
	localparam logic [31:0] RST_MSI_CAP        = 32'h0080_5c05;
	localparam logic [31:0] RST_PRODUCT_CAP    = 32'h0000_6403;
	localparam logic [31:0] RST_VENDOR_CAP     = 32'h0034_b009;
	localparam logic [31:0] RST_SUBSYS_CAP     = 32'h0000_c00d;
	localparam logic [31:0] RST_PCIE_CAP       = 32'h0052_0010;
	localparam logic [31:0] RST_LINK_CAPS      = 32'h0000_0012;
	localparam logic [31:0] RST_LINK_CAPS2     = 32'h0000_0006;
	localparam logic [31:0] RST_LINK_CTRL2     = 32'h0000_0002;

	// ----------------------------------------
	// positions of fields wired to hardware ports
	// ----------------------------------------
	localparam int STATUS_EVENT_LSB = 27;
	localparam int PME_STATUS_BIT   = 15;
	localparam int PIN_IN_LSB       = 16;
	localparam int LINK_STATUS_LSB  = 16;
	localparam int BUS_MASTER_BIT   = 2;

endpackage : switch_cfg_pkg

// File: core/switch_port_bridge_config_space.sv
`timescale 1ns/1ps
// Overview of operation
// R1: write one clears bit, zero keeps it
// R2: sticky bits survive hot reset
// R3: port shows bridge with type 1 header
// R4: capability pointer returns 40h
// R5: power capability id 01, next 4C
// R6: express capability at C0h, id 10
// R7: 64-bit prefetch upper base/limit at 28h/2Ch
// R8: second-generation capability and control words present
// R9: management port writes every read-write field
// R10: management port also writes preloadable read-only
// R11: reserved offsets read zero, ignore writes
module switch_port_bridge_config_space #(
	parameter logic [15:0] VENDOR_CODE = 16'h1a2b, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h3c4d, // arbitrary value
	parameter logic [31:0] SUBSYS_CODE = 32'h0000_5e6f  // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hot_rst,
	input  wire logic        cfg_req,
	input  wire logic        cfg_we,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic      [31:0] cfg_rdata,
	input  wire logic        smb_req,
	input  wire logic        smb_we,
	input  wire logic [7:0]  smb_addr,
	input  wire logic [3:0]  smb_be,
	input  wire logic [31:0] smb_wdata,
	output logic             smb_ack,
	output logic      [31:0] smb_rdata,
	input  wire logic [4:0]  status_event,
	input  wire logic        pme_event,
	input  wire logic [7:0]  pin_in,
	input  wire logic [13:0] link_status,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe,
	output logic             bus_master_en
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [63:0][31:0] word;
		logic              cfg_ack;
		logic [31:0]       cfg_rdata;
		logic              smb_ack;
		logic [31:0]       smb_rdata;
		logic [7:0]        pin_out;
		logic [7:0]        pin_oe;
		logic              bus_master_en;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ----------------------------------------
	// attribute table
	// ----------------------------------------
	function automatic switch_cfg_pkg::attr_t mk(
			input logic [31:0] rst,
			input logic [31:0] rw,
			input logic [31:0] w1c,
			input logic [31:0] stk,
			input logic [31:0] pre);
		mk = '{1'b1, rst, rw, w1c, stk, pre};
	endfunction : mk

	function automatic switch_cfg_pkg::attr_t attr(input logic [5:0] idx);
		switch_cfg_pkg::attr_t a;
		a = '0;
		case ({idx, 2'b00})
			// ----------------------------------------
			// identity, command and class words
			// ----------------------------------------
			switch_cfg_pkg::OFS_IDENT_WORD: begin
				a = mk({DEVICE_CODE, VENDOR_CODE}, '0, '0, '0, '1); // R10
			end
			switch_cfg_pkg::OFS_COMMAND_STATUS: begin
				a = mk(switch_cfg_pkg::RST_COMMAND_STATUS, 32'h0000_0547, 32'hf900_0000, '0, '0); // R1
			end
			switch_cfg_pkg::OFS_CLASS_REVISION: begin
				a = mk(switch_cfg_pkg::RST_CLASS_REVISION, '0, '0, '0, '1);
			end
			switch_cfg_pkg::OFS_HEADER_TYPE: begin
				a = mk(switch_cfg_pkg::RST_HEADER_TYPE, 32'h0000_00ff, '0, '0, '0); // R3
			end

			// ----------------------------------------
			// bus numbers and forwarding windows
			// ----------------------------------------
			switch_cfg_pkg::OFS_BUS_NUMBERS: begin
				a = mk('0, 32'h00ff_ffff, '0, '0, '0); // R9
			end
			switch_cfg_pkg::OFS_IO_WINDOW: begin
				a = mk(switch_cfg_pkg::RST_IO_WINDOW, 32'h0000_f0f0, 32'hf900_0000, '0, '0); // R1
			end
			switch_cfg_pkg::OFS_MEMORY_WINDOW: begin
				a = mk('0, 32'hfff0_fff0, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_PREFETCH_WIN: begin
				a = mk(switch_cfg_pkg::RST_PREFETCH_WIN, 32'hfff0_fff0, '0, '0, '0); // R7
			end
			switch_cfg_pkg::OFS_PREF_BASE_HI,
			switch_cfg_pkg::OFS_PREF_LIMIT_HI: begin
				a = mk('0, '1, '0, '0, '0); // R7
			end
			switch_cfg_pkg::OFS_IO_WINDOW_HI: begin
				a = mk('0, '1, '0, '0, '0);
			end

			// ----------------------------------------
			// capability pointer and bridge control
			// ----------------------------------------
			switch_cfg_pkg::OFS_FIRST_CAP_PTR: begin
				a = mk(switch_cfg_pkg::RST_FIRST_CAP_PTR, '0, '0, '0, '0); // R4
			end
			switch_cfg_pkg::OFS_INTR_BRIDGE: begin
				a = mk(switch_cfg_pkg::RST_INTR_BRIDGE, 32'h0fff_00ff, '0, '0, '0);
			end

			// ----------------------------------------
			// power management capability
			// ----------------------------------------
			switch_cfg_pkg::OFS_POWER_CAP: begin
				a = mk(switch_cfg_pkg::RST_POWER_CAP, '0, '0, '0, 32'hffff_0000); // R5
			end
			switch_cfg_pkg::OFS_POWER_CTRL: begin
				a = mk('0, 32'h0000_0103, 32'h0000_8000, 32'h0000_8100, '0); // R2
			end

			// ----------------------------------------
			// message interrupt capability
			// ----------------------------------------
			switch_cfg_pkg::OFS_MSI_CAP: begin
				a = mk(switch_cfg_pkg::RST_MSI_CAP, 32'h0071_0000, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_MSI_ADDR_LO: begin
				a = mk('0, 32'hffff_fffc, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_MSI_ADDR_HI: begin
				a = mk('0, '1, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_MSI_PAYLOAD: begin
				a = mk('0, 32'h0000_ffff, '0, '0, '0);
			end

			// ----------------------------------------
			// product data and vendor headers
			// ----------------------------------------
			switch_cfg_pkg::OFS_PRODUCT_CAP: begin
				a = mk(switch_cfg_pkg::RST_PRODUCT_CAP, 32'hffff_0000, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_PRODUCT_WORD: begin
				a = mk('0, '1, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_VENDOR_CAP: begin
				a = mk(switch_cfg_pkg::RST_VENDOR_CAP, '0, '0, '0, '0);
			end

			// ----------------------------------------
			// vendor tuning words
			// ----------------------------------------
			// vendor tuning words are sticky so link setup survives hot reset
			switch_cfg_pkg::OFS_LINK_WORD0,
			switch_cfg_pkg::OFS_LINK_WORD1,
			switch_cfg_pkg::OFS_SWITCH_MODES,
			switch_cfg_pkg::OFS_PHY1_WORD2,
			switch_cfg_pkg::OFS_PHY_PARAM2,
			switch_cfg_pkg::OFS_LINK_WORD3,
			switch_cfg_pkg::OFS_LINK_WORD4,
			switch_cfg_pkg::OFS_LINK_WORD5,
			switch_cfg_pkg::OFS_TRANS_LINK,
			switch_cfg_pkg::OFS_PHY_PARAM3: begin
				a = mk('0, '1, '0, '1, '0); // R2
			end
			switch_cfg_pkg::OFS_ACK_REPLAY: begin
				a = mk('0, 32'h7fff_1fff, '0, 32'h7fff_1fff, '0);
			end
			switch_cfg_pkg::OFS_PHY_TX_MARGIN,
			switch_cfg_pkg::OFS_BUFFER_OP_MODE: begin
				a = mk('0, 32'h00ff_ffff, '0, 32'h00ff_ffff, '0);
			end

			// ----------------------------------------
			// subsystem ids, pins and serial rom
			// ----------------------------------------
			switch_cfg_pkg::OFS_SUBSYS_CAP: begin
				a = mk(switch_cfg_pkg::RST_SUBSYS_CAP, '0, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_SUBSYS_IDENT: begin
				a = mk(SUBSYS_CODE, '0, '0, '0, '1); // R10
			end
			switch_cfg_pkg::OFS_PIN_IO: begin
				a = mk('0, 32'h0000_ffff, '0, '0, '0);
			end
			switch_cfg_pkg::OFS_SERIAL_ROM: begin
				a = mk('0, '1, '0, '0, '0);
			end

			// ----------------------------------------
			// express capability
			// ----------------------------------------
			switch_cfg_pkg::OFS_PCIE_CAP: begin
				a = mk(switch_cfg_pkg::RST_PCIE_CAP, '0, '0, '0, 32'hffff_0000); // R6
			end
			switch_cfg_pkg::OFS_DEVICE_CAPS: begin
				a = mk('0, '0, '0, '0, '1);
			end
			switch_cfg_pkg::OFS_DEVICE_CTRL: begin
				a = mk('0, 32'h0000_ffff, 32'h000f_0000, '0, '0);
			end
			switch_cfg_pkg::OFS_LINK_CAPS: begin
				a = mk(switch_cfg_pkg::RST_LINK_CAPS, '0, '0, '0, '1);
			end
			switch_cfg_pkg::OFS_LINK_CTRL: begin
				a = mk('0, 32'h0000_0ffb, 32'hc000_0000, '0, '0);
			end
			switch_cfg_pkg::OFS_SLOT_CAPS: begin
				a = mk('0, '0, '0, '0, '1);
			end
			switch_cfg_pkg::OFS_SLOT_CTRL: begin
				a = mk('0, 32'h0000_1fff, 32'h011f_0000, '0, '0);
			end

			// ----------------------------------------
			// second-generation words
			// ----------------------------------------
			switch_cfg_pkg::OFS_DEVICE_CAPS2: begin
				a = mk('0, '0, '0, '0, '1); // R8
			end
			switch_cfg_pkg::OFS_DEVICE_CTRL2: begin
				a = mk('0, 32'h0000_003f, '0, '0, '0); // R8
			end
			switch_cfg_pkg::OFS_LINK_CAPS2: begin
				a = mk(switch_cfg_pkg::RST_LINK_CAPS2, '0, '0, '0, '1); // R8
			end
			switch_cfg_pkg::OFS_LINK_CTRL2: begin
				a = mk(switch_cfg_pkg::RST_LINK_CTRL2, 32'h0000_1fff, '0, '0, '0); // R8
			end
			switch_cfg_pkg::OFS_SLOT_CAPS2,
			switch_cfg_pkg::OFS_SLOT_CTRL2: begin
				a = mk('0, '0, '0, '0, '0); // R8
			end
			default: begin
				a = '0; // R11
			end
		endcase
		return a;
	endfunction : attr

	// ----------------------------------------
	// write merge
	// ----------------------------------------
	function automatic logic [31:0] lanes(input logic [3:0] be);
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lanes

	function automatic logic [31:0] merge(
			input logic [31:0]           cur,
			input switch_cfg_pkg::attr_t a,
			input logic [31:0]           wd,
			input logic [3:0]            be,
			input logic                  mgmt);
		logic [31:0] m;
		logic [31:0] wm;
		m  = lanes(be);
		wm = (a.rw | (mgmt ? a.pre : 32'h0)) & m; // R9 R10
		merge = ((cur & ~wm) | (wd & wm)) & ~(wd & a.w1c & m); // R1
	endfunction : merge

	function automatic state_t reset_state();
		state_t                r;
		switch_cfg_pkg::attr_t a;
		r = '0;
		for (int i = 0; i < 64; i++) begin
			a         = attr(6'(i));
			r.word[i] = a.rst;
		end
		return r;
	endfunction : reset_state

	localparam state_t RESET_S = reset_state();

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		switch_cfg_pkg::attr_t a;
		logic [5:0]            ci;
		logic [5:0]            si;
		a  = '0;
		ci = cfg_addr[7:2];
		si = smb_addr[7:2];
		s_d = s_q;
		s_d.cfg_ack = 1'b0;
		s_d.smb_ack = 1'b0;

		// ----------------------------------------
		// hot reset: sticky and preload bits stay
		// ----------------------------------------
		if (hot_rst) begin
			// preload survives too, or the rom contents would be lost
			for (int i = 0; i < 64; i++) begin
				a = attr(6'(i));
				s_d.word[i] = (s_q.word[i] & (a.stk | a.pre)) | (a.rst & ~(a.stk | a.pre)); // R2
			end
		end

		// ----------------------------------------
		// host port
		// ----------------------------------------
		if (cfg_req) begin
			a = attr(ci);
			s_d.cfg_ack = 1'b1;
			if (cfg_we) begin
				s_d.word[ci] = merge(s_d.word[ci], a, cfg_wdata, cfg_be, 1'b0);
			end else begin
				s_d.cfg_rdata = a.impl ? s_q.word[ci] : 32'h0; // R11
			end
		end

		// ----------------------------------------
		// management port
		// ----------------------------------------
		// management port lands after the host when both hit one word
		if (smb_req) begin
			a = attr(si);
			s_d.smb_ack = 1'b1;
			if (smb_we) begin
				s_d.word[si] = merge(s_d.word[si], a, smb_wdata, smb_be, 1'b1); // R9
			end else begin
				s_d.smb_rdata = a.impl ? s_q.word[si] : 32'h0; // R11
			end
		end
		// ----------------------------------------
		// hardware events: set wins over clear
		// ----------------------------------------
		s_d.word[switch_cfg_pkg::OFS_COMMAND_STATUS[7:2]][switch_cfg_pkg::STATUS_EVENT_LSB +: 5] =
			s_d.word[switch_cfg_pkg::OFS_COMMAND_STATUS[7:2]][switch_cfg_pkg::STATUS_EVENT_LSB +: 5] |
			status_event; // R1
		if (pme_event) begin
			s_d.word[switch_cfg_pkg::OFS_POWER_CTRL[7:2]][switch_cfg_pkg::PME_STATUS_BIT] = 1'b1; // R2
		end
		s_d.word[switch_cfg_pkg::OFS_PIN_IO[7:2]][switch_cfg_pkg::PIN_IN_LSB +: 8] = pin_in;
		s_d.word[switch_cfg_pkg::OFS_LINK_CTRL[7:2]][switch_cfg_pkg::LINK_STATUS_LSB +: 14] = link_status;
		s_d.pin_out = s_d.word[switch_cfg_pkg::OFS_PIN_IO[7:2]][7:0];
		s_d.pin_oe  = s_d.word[switch_cfg_pkg::OFS_PIN_IO[7:2]][15:8];
		s_d.bus_master_en = s_d.word[switch_cfg_pkg::OFS_COMMAND_STATUS[7:2]][switch_cfg_pkg::BUS_MASTER_BIT];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= RESET_S;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_ack       = s_q.cfg_ack;
	assign cfg_rdata     = s_q.cfg_rdata;
	assign smb_ack       = s_q.smb_ack;
	assign smb_rdata     = s_q.smb_rdata;
	assign pin_out       = s_q.pin_out;
	assign pin_oe        = s_q.pin_oe;
	assign bus_master_en = s_q.bus_master_en;

endmodule : switch_port_bridge_config_space

// File: verification/cfg_space_monitor.sv
`timescale 1ns/1ps
module cfg_space_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cfg_req,
	input wire logic        cfg_we,
	input wire logic [7:0]  cfg_addr,
	input wire logic        cfg_ack,
	input wire logic [31:0] cfg_rdata,
	input wire logic        smb_req,
	input wire logic        smb_ack
);
	// ----------------------------------------
	// host and management port checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rd;
	assign rd = cfg_req && !cfg_we;
	a_cfg_ack_delay: assert property (cfg_req |=> cfg_ack) else $error("host ack missing");
	a_cfg_ack_cause: assert property (cfg_ack |-> $past(cfg_req)) else $error("host ack unasked");
	a_smb_ack_delay: assert property (smb_req |=> smb_ack) else $error("mgmt ack missing");
	a_smb_ack_cause: assert property (smb_ack |-> $past(smb_req)) else $error("mgmt ack unasked");
	a_header_kind: assert property (rd && cfg_addr[7:2] == 6'h03 |=> cfg_rdata[23:16] == 8'h01)
		else $error("header kind wrong");
	a_first_pointer: assert property (rd && cfg_addr[7:2] == 6'h0d |=> cfg_rdata == 32'h0000_0040)
		else $error("first pointer wrong");
	a_power_chain: assert property (rd && cfg_addr[7:2] == 6'h10 |=> cfg_rdata[15:0] == 16'h4c01)
		else $error("power header wrong");
	a_express_id: assert property (rd && cfg_addr[7:2] == 6'h30 |=> cfg_rdata[7:0] == 8'h10)
		else $error("express id wrong");
	a_reserved_zero: assert property (rd && cfg_addr[7:2] inside {6'h04, 6'h05, 6'h0e, [6'h27:6'h2b],
		6'h37, 6'h38, 6'h3f} |=> cfg_rdata == 32'h0) else $error("reserved word not zero");
	// the main traffic kinds, so a silent bench shows up
	c_host_write: cover property (cfg_req && cfg_we ##1 cfg_ack);
	c_host_read: cover property (rd ##1 cfg_ack);
	c_both_ports: cover property (cfg_req && smb_req);
endmodule : cfg_space_monitor

bind switch_port_bridge_config_space cfg_space_monitor mon (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
	.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .smb_req(smb_req),
	.smb_ack(smb_ack));

// File: verification/host_requester.sv
`timescale 1ns/1ps
module host_requester (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic        go_we,
	input  wire logic [7:0]  go_addr,
	input  wire logic [3:0]  go_be,
	input  wire logic [31:0] go_wdata,
	output logic             req,
	output logic             we,
	output logic      [7:0]  addr,
	output logic      [3:0]  be,
	output logic      [31:0] wdata,
	input  wire logic        ack,
	input  wire logic [31:0] rdata,
	output logic             rd_done,
	output logic      [31:0] rd_data
);
	// ----------------------------------------
	// one request per go, read data handed back
	// ----------------------------------------
	logic pend_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{req, we, addr, be, wdata, pend_q, rd_done, rd_data} <= '0;
		end else begin
			req     <= go;
			// idle qualifiers toggle so stale values never pass for valid ones
			we      <= go ? go_we : ~we;
			addr    <= go ? go_addr : ~addr;
			be      <= go ? go_be : ~be;
			wdata   <= go ? go_wdata : ~wdata;
			pend_q  <= req && !we;
			rd_done <= ack && pend_q;
			rd_data <= rdata;
		end
	end
endmodule : host_requester

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] v;
	} note_t;
	localparam logic [7:0]  RA [14] = '{8'h00, 8'h04, 8'h0c, 8'h34, 8'h40, 8'h4c, 8'h64, 8'hb0, 8'hc0, 8'hf0,
		8'h10, 8'h38, 8'h9c, 8'hfc};
	localparam logic [31:0] RV [14] = '{32'h3c4d_1a2b, 32'h0010_0000, 32'h0001_0000, 32'h0000_0040,
		32'h0003_4c01, 32'h0080_5c05, 32'h0034_b009, 32'h0000_c00d, 32'h0052_0010, 32'h0000_0002,
		32'h0, 32'h0, 32'h0, 32'h0};
	logic             clk = 1'b0, rst_n = 1'b0, hot_rst = 1'b0, pme_event = 1'b0;
	logic [4:0]       status_event = 5'h00;
	logic [7:0]       pin_in = 8'h00;
	logic [13:0]      link_status = 14'h0000;
	logic [1:0]       go = 2'h0, gwe = 2'h0;
	logic [1:0][7:0]  ga = '0;
	logic [1:0][3:0]  gb = '0;
	logic [1:0][31:0] gd = '0;
	wire logic [1:0]       req, we, ack, rdn;
	wire logic [1:0][7:0]  addr;
	wire logic [1:0][3:0]  be;
	wire logic [1:0][31:0] wd, rdt, rdd;
	wire logic [7:0]       pin_out, pin_oe;
	wire logic             bus_master_en;
	note_t       q [2][$];
	int          miscompares = 0, check_count = 0, cyc = 0;
	logic [31:0] d, e;

	always #4 clk = ~clk;
	for (genvar p = 0; p < 2; p++) begin : g_host
		host_requester h (.clk(clk), .rst_n(rst_n), .go(go[p]), .go_we(gwe[p]), .go_addr(ga[p]), .go_be(gb[p]),
			.go_wdata(gd[p]), .req(req[p]), .we(we[p]), .addr(addr[p]), .be(be[p]), .wdata(wd[p]),
			.ack(ack[p]), .rdata(rdt[p]), .rd_done(rdn[p]), .rd_data(rdd[p]));
	end
	switch_port_bridge_config_space uut (.clk(clk), .rst_n(rst_n), .hot_rst(hot_rst), .cfg_req(req[0]),
		.cfg_we(we[0]), .cfg_addr(addr[0]), .cfg_be(be[0]), .cfg_wdata(wd[0]), .cfg_ack(ack[0]),
		.cfg_rdata(rdt[0]), .smb_req(req[1]), .smb_we(we[1]), .smb_addr(addr[1]), .smb_be(be[1]),
		.smb_wdata(wd[1]), .smb_ack(ack[1]), .smb_rdata(rdt[1]), .status_event(status_event),
		.pme_event(pme_event), .pin_in(pin_in), .link_status(link_status), .pin_out(pin_out),
		.pin_oe(pin_oe), .bus_master_en(bus_master_en));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input logic [7:0] a, input logic [31:0] x, input logic [31:0] s);
		check_count++;
		if (s !== x) begin
			miscompares++;
			$display("unexpected word %h: expected %h seen %h", a, x, s);
		end
	endtask : cmp
	// port 0 is the host, port 1 the management side; reads note their expectation
	task automatic acc(input int p, input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] wv, input logic [31:0] x);
		@(posedge clk);
		go[p] <= 1'b1;
		gwe[p] <= w;
		ga[p] <= a;
		gb[p] <= b;
		gd[p] <= wv;
		if (!w) q[p].push_back({a, x});
		@(posedge clk);
		go[p] <= 1'b0;
	endtask : acc
	task automatic results();
		// reads that never came back count against the run
		miscompares += q[0].size() + q[1].size();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	// ----------------------------------------
	// result watcher and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		note_t n;
		for (int p = 0; p < 2; p++) if (rdn[p] === 1'b1) begin
			n = q[p].pop_front();
			cmp(n.a, n.v, rdd[p]);
		end
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			results();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(22178));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 14; i++) acc(0, 1'b0, RA[i], 4'hf, 32'h0, RV[i]);
		$display("test reset values done");
		d = $urandom;
		acc(0, 1'b1, 8'h28, 4'hf, d, 32'h0);
		acc(0, 1'b1, 8'h2c, 4'hf, ~d, 32'h0);
		acc(0, 1'b0, 8'h28, 4'hf, 32'h0, d);
		acc(0, 1'b0, 8'h2c, 4'hf, 32'h0, ~d);
		acc(0, 1'b1, 8'h10, 4'hf, d, 32'h0);
		acc(0, 1'b0, 8'h10, 4'hf, 32'h0, 32'h0);
		acc(0, 1'b1, 8'he8, 4'hf, 32'hffff_ffff, 32'h0);
		acc(0, 1'b0, 8'he8, 4'hf, 32'h0, 32'h0000_003f);
		acc(0, 1'b1, 8'hf0, 4'h1, 32'hffff_ffff, 32'h0);
		acc(0, 1'b0, 8'hf0, 4'hf, 32'h0, 32'h0000_00ff);
		$display("test windows done");
		@(posedge clk) status_event <= 5'h01;
		@(posedge clk) status_event <= 5'h00;
		acc(0, 1'b1, 8'h04, 4'h8, 32'h0, 32'h0);
		acc(0, 1'b0, 8'h04, 4'hf, 32'h0, 32'h0810_0000);
		acc(0, 1'b1, 8'h04, 4'h8, 32'h0800_0000, 32'h0);
		acc(0, 1'b0, 8'h04, 4'hf, 32'h0, 32'h0010_0000);
		acc(0, 1'b1, 8'h04, 4'h1, 32'h0000_0004, 32'h0);
		repeat (3) @(posedge clk);
		#1 cmp(8'h04, 32'h1, {31'h0, bus_master_en});
		$display("test clear on one done");
		d = $urandom;
		acc(0, 1'b1, 8'h68, 4'hf, d, 32'h0);
		acc(0, 1'b1, 8'h18, 4'hf, d, 32'h0);
		@(posedge clk) pme_event <= 1'b1;
		@(posedge clk) {pme_event, hot_rst} <= 2'b01;
		@(posedge clk) hot_rst <= 1'b0;
		acc(0, 1'b0, 8'h68, 4'hf, 32'h0, d);
		acc(0, 1'b0, 8'h18, 4'hf, 32'h0, 32'h0);
		acc(0, 1'b0, 8'h44, 4'hf, 32'h0, 32'h0000_8000);
		acc(0, 1'b1, 8'h44, 4'h2, 32'h0000_8000, 32'h0);
		acc(0, 1'b0, 8'h44, 4'hf, 32'h0, 32'h0);
		$display("test sticky done");
		d = $urandom;
		e = $urandom;
		acc(1, 1'b1, 8'h00, 4'hf, d, 32'h0);
		acc(0, 1'b0, 8'h00, 4'hf, 32'h0, d);
		acc(0, 1'b1, 8'h00, 4'hf, ~d, 32'h0);
		acc(1, 1'b0, 8'h00, 4'hf, 32'h0, d);
		acc(1, 1'b1, 8'h54, 4'hf, e, 32'h0);
		acc(0, 1'b0, 8'h54, 4'hf, 32'h0, e);
		fork
			acc(0, 1'b1, 8'h18, 4'hf, d, 32'h0);
			acc(1, 1'b1, 8'h18, 4'h1, e, 32'h0);
		join
		acc(1, 1'b0, 8'h18, 4'hf, 32'h0, {8'h00, d[23:8], e[7:0]});
		$display("test management port done");
		pin_in <= 8'($urandom);
		link_status <= 14'($urandom);
		acc(0, 1'b1, 8'hb8, 4'h3, d, 32'h0);
		acc(0, 1'b0, 8'hb8, 4'hf, 32'h0, {8'h00, pin_in, d[15:0]});
		acc(0, 1'b0, 8'hd0, 4'hf, 32'h0, {2'b00, link_status, 16'h0000});
		repeat (2) @(posedge clk);
		#1 cmp(8'hb8, {16'h0, d[15:0]}, {16'h0, pin_oe, pin_out});
		repeat (4) @(posedge clk);
		$display("test pins done");
		results();
	end
endmodule : tb
